// ==== common/clk_lock_pkg.sv ====
package clk_lock_pkg;

  localparam int          ADDR_W   = 12;
  localparam int          DATA_W   = 32;

  // Byte addresses of the registers
  localparam logic [11:0] OFS_CLOCK_LOCKS = 12'h03C;
  localparam logic [11:0] OFS_SEC_CTRL    = 12'h040;
  localparam logic [11:0] OFS_SEC_LOCK    = 12'h044;
  localparam logic [11:0] OFS_OSC_CTRL    = 12'h048;
  localparam logic [11:0] OFS_SCRATCH0    = 12'h100;
  localparam logic [11:0] OFS_SCRATCH1    = 12'h104;

  // Lock bit positions in clock_setting_locks
  localparam int FAST_OSC_TEST_IN4_LOCK     = 31;
  localparam int FAST_OSC_TEST_IN3_LOCK     = 30;
  localparam int FAST_OSC_TEST_IN2_LOCK     = 29;
  localparam int FAST_OSC_TEST_IN1_LOCK     = 28;
  localparam int FAST_OSC_FACTORY_TRIM_LOCK = 27;
  localparam int CRYSTAL_TRIM_LOCK          = 26;
  localparam int FAST_OSC_TEMP_CTRL_LOCK    = 25;
  localparam int FAST_OSC_BIAS_LOCK         = 24;
  localparam int FAST_OSC_STARTUP_LOCK      = 23;
  localparam int FAST_OSC_BYPASS_LOCK       = 22;
  localparam int SLOW_OSC_DEBUG2_LOCK       = 20;
  localparam int SLOW_OSC_DEBUG1_LOCK       = 19;
  localparam int SLOW_OSC_BYPASS_LOCK       = 18;
  localparam int RTC_DIVIDER_LOCK           = 13;
  localparam int SLOW_OSC_POWERDOWN_LOCK    = 12;
  localparam int FAST_OSC_POWERDOWN_LOCK    = 11;

  // Defined lock bits; all others are reserved
  localparam logic [31:0] LOCK_MASK = 32'hFFDC_3800;
  localparam logic [31:0] LOCKS_RST = 32'h0000_0000;

  // Security override and its lock
  localparam int   SEC_OVERRIDE_BIT = 0;
  localparam int   SEC_LOCK_BIT     = 0;
  localparam logic SEC_OVERRIDE_RST = 1'b0;
  localparam logic SEC_LOCK_RST     = 1'b0;
  localparam logic JTAG_DENY_RST    = 1'b1;

  // Oscillator control fields guarded by the locks
  localparam int         RTC_DIV_LSB    = 3;
  localparam int         RTC_DIV_W      = 4;
  localparam int         RTC_APPLY_BIT  = 2;
  localparam int         RTC_EN_BIT     = 1;
  localparam int         SLOW_PD_BIT    = 12;
  localparam int         FAST_PD_BIT    = 11;
  localparam logic [3:0] RTC_DIV_RST    = 4'h0;
  localparam logic       RTC_APPLY_RST  = 1'b1;
  localparam logic       RTC_EN_RST     = 1'b1;
  localparam logic       PD_RST         = 1'b0;

  localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  typedef struct packed {
    logic [3:0] rtc_divider_value;
    logic       rtc_div_apply;
    logic       rtc_clk_en;
    logic       slow_osc_pd;
    logic       fast_osc_pd;
  } osc_ctrl_s;

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    return addr == ofs;
  endfunction : hit

endpackage : clk_lock_pkg

// ==== hw/lock_field.sv ====
`timescale 1ns/1ps
// Field that ignores writes while its lock is set
module lock_field #(
  parameter int unsigned      W   = 1,
  parameter logic [W-1:0]     RST = '0
) (
  // Clock and clear
  input  wire logic         clk,
  input  wire logic         clr,
  // Write side
  input  wire logic         wr,
  input  wire logic         lock,
  input  wire logic [W-1:0] d,
  // Stored value
  output logic      [W-1:0] q
);

  always_ff @(posedge clk) begin
    if (clr) begin
      q <= RST;
    end else if (wr && !lock) begin
      q <= d;
    end
  end

endmodule : lock_field

// ==== hw/clock_lock_regs.sv ====
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module clock_lock_regs (
  // Clock, resets and enable
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    ce,
  input  wire logic                    cold_rst,
  input  wire logic                    warm_rst,
  // Register port
  input  wire clk_lock_pkg::reg_req_s  req,
  output logic [31:0]                  rdata,
  // Security
  input  wire logic                    otp_area_programmed,
  output logic                         security_override,
  output logic                         jtag_tap_deny,
  // Clock control
  output logic [31:0]                  clock_locks,
  output clk_lock_pkg::osc_ctrl_s      osc_ctrl,
  output logic                         rtc_div_load
);
  import clk_lock_pkg::*;

  logic [31:0] clock_lock_r;
  logic [31:0] clock_lock_nxt;
  logic        sec_lock_r;
  logic        sec_lock_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        jtag_deny_r;
  logic        jtag_deny_nxt;
  logic        load_r;
  logic        load_nxt;

  logic        sec_ovr_q;
  logic [31:0] scratch0_q;
  logic [31:0] scratch1_q;
  logic [3:0]  rtc_div_q;
  logic        rtc_apply_q;
  logic        rtc_en_q;
  logic        slow_pd_q;
  logic        fast_pd_q;

  // Address decode
  wire         sel_locks   = hit(req.addr, OFS_CLOCK_LOCKS);
  wire         sel_sec     = hit(req.addr, OFS_SEC_CTRL);
  wire         sel_sec_lk  = hit(req.addr, OFS_SEC_LOCK);
  wire         sel_osc     = hit(req.addr, OFS_OSC_CTRL);
  wire         sel_scr0    = hit(req.addr, OFS_SCRATCH0);
  wire         sel_scr1    = hit(req.addr, OFS_SCRATCH1);

  // Write strobes, gated by the clock enable
  wire         wr_go       = ce & req.wr;
  wire         wr_locks    = wr_go & sel_locks;
  wire         wr_sec      = wr_go & sel_sec;
  wire         wr_sec_lk   = wr_go & sel_sec_lk;
  wire         wr_osc      = wr_go & sel_osc;
  wire         wr_scr0     = wr_go & sel_scr0;
  wire         wr_scr1     = wr_go & sel_scr1;

  // Power reset loads every reset value (JTAG denial, RTC apply and enable load 1); cold reset loads those of the sticky fields
  wire         cold_clr    = srst | (ce & cold_rst);

  wire [31:0]  lock_set_bits = req.wdata & LOCK_MASK;
  wire         rtc_locked  = clock_lock_r[RTC_DIVIDER_LOCK];
  wire         slow_pd_lk  = clock_lock_r[SLOW_OSC_POWERDOWN_LOCK];
  wire         fast_pd_lk  = clock_lock_r[FAST_OSC_POWERDOWN_LOCK];

  // Lock bits only ever set here
  assign clock_lock_nxt = wr_locks ? (clock_lock_r | lock_set_bits)
                                   : clock_lock_r;
  assign sec_lock_nxt   = sec_lock_r | (wr_sec_lk & req.wdata[SEC_LOCK_BIT]);

  always_ff @(posedge clk) begin
    if (srst) begin
      clock_lock_r <= LOCKS_RST;
      sec_lock_r   <= SEC_LOCK_RST;
    end else if (ce) begin
      clock_lock_r <= clock_lock_nxt;
      sec_lock_r   <= sec_lock_nxt;
    end
  end

  // Security override, held against writes while its lock is set; cold reset still clears it
  lock_field #(
    .W   (1),
    .RST (SEC_OVERRIDE_RST)
  ) u_sec_override (
    .clk  (clk),
    .clr  (cold_clr),
    .wr   (wr_sec),
    .lock (sec_lock_r),
    .d    (req.wdata[SEC_OVERRIDE_BIT]),
    .q    (sec_ovr_q)
  );

  // Sticky scratch words: no warm reset input
  lock_field #(
    .W   (32),
    .RST (SCRATCH_RST)
  ) u_scratch0 (
    .clk  (clk),
    .clr  (cold_clr),
    .wr   (wr_scr0),
    .lock (1'b0),
    .d    (req.wdata),
    .q    (scratch0_q)
  );

  lock_field #(
    .W   (32),
    .RST (SCRATCH_RST)
  ) u_scratch1 (
    .clk  (clk),
    .clr  (cold_clr),
    .wr   (wr_scr1),
    .lock (1'b0),
    .d    (req.wdata),
    .q    (scratch1_q)
  );

  // RTC divider fields
  lock_field #(
    .W   (RTC_DIV_W),
    .RST (RTC_DIV_RST)
  ) u_rtc_div (
    .clk  (clk),
    .clr  (cold_clr),
    .wr   (wr_osc),
    .lock (rtc_locked),
    .d    (req.wdata[RTC_DIV_LSB +: RTC_DIV_W]),
    .q    (rtc_div_q)
  );

  lock_field #(
    .W   (1),
    .RST (RTC_APPLY_RST)
  ) u_rtc_apply (
    .clk  (clk),
    .clr  (cold_clr),
    .wr   (wr_osc),
    .lock (rtc_locked),
    .d    (req.wdata[RTC_APPLY_BIT]),
    .q    (rtc_apply_q)
  );

  lock_field #(
    .W   (1),
    .RST (RTC_EN_RST)
  ) u_rtc_en (
    .clk  (clk),
    .clr  (cold_clr),
    .wr   (wr_osc),
    .lock (rtc_locked),
    .d    (req.wdata[RTC_EN_BIT]),
    .q    (rtc_en_q)
  );

  // Oscillator power-down controls
  lock_field #(
    .W   (1),
    .RST (PD_RST)
  ) u_slow_pd (
    .clk  (clk),
    .clr  (cold_clr),
    .wr   (wr_osc),
    .lock (slow_pd_lk),
    .d    (req.wdata[SLOW_PD_BIT]),
    .q    (slow_pd_q)
  );

  lock_field #(
    .W   (1),
    .RST (PD_RST)
  ) u_fast_pd (
    .clk  (clk),
    .clr  (cold_clr),
    .wr   (wr_osc),
    .lock (fast_pd_lk),
    .d    (req.wdata[FAST_PD_BIT]),
    .q    (fast_pd_q)
  );

  // Divider is applied on a written 0 to 1 edge of the apply bit
  assign load_nxt = wr_osc & ~rtc_locked & ~cold_clr
                    & req.wdata[RTC_APPLY_BIT] & ~rtc_apply_q;

  // Read views, reserved bits zero
  wire [31:0] rd_sec   = {31'h0000_0000, sec_ovr_q};
  wire [31:0] rd_sec_l = {31'h0000_0000, sec_lock_r};
  wire [31:0] rd_osc   = {19'h0_0000, slow_pd_q, fast_pd_q, 4'h0,
                          rtc_div_q, rtc_apply_q, rtc_en_q, 1'b0};

  wire [31:0] rd_mux   = sel_locks  ? (clock_lock_r & LOCK_MASK) :
                         sel_sec    ? rd_sec :
                         sel_sec_lk ? rd_sec_l :
                         sel_osc    ? rd_osc :
                         sel_scr0   ? scratch0_q :
                         sel_scr1   ? scratch1_q :
                                      ZERO_WORD;

  assign rdata_nxt     = req.rd ? rd_mux : ZERO_WORD;
  assign jtag_deny_nxt = otp_area_programmed & ~sec_ovr_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r     <= ZERO_WORD;
      jtag_deny_r <= JTAG_DENY_RST;
      load_r      <= 1'b0;
    end else if (ce) begin
      rdata_r     <= warm_rst ? ZERO_WORD : rdata_nxt;
      jtag_deny_r <= jtag_deny_nxt;
      load_r      <= warm_rst ? 1'b0 : load_nxt;
    end
  end

  assign rdata             = rdata_r;
  assign jtag_tap_deny     = jtag_deny_r;
  assign rtc_div_load      = load_r;
  assign security_override = sec_ovr_q;
  assign clock_locks       = clock_lock_r;
  assign osc_ctrl          = '{rtc_divider_value: rtc_div_q,
                               rtc_div_apply:     rtc_apply_q,
                               rtc_clk_en:        rtc_en_q,
                               slow_osc_pd:       slow_pd_q,
                               fast_osc_pd:       fast_pd_q};

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_lock_write;
    ce && wr_locks && !warm_rst;
  endsequence

  sequence s_lock_read;
    ce && req.rd && sel_locks && !warm_rst;
  endsequence

  sequence s_apply_rise;
    wr_osc && !rtc_locked && !cold_rst && req.wdata[RTC_APPLY_BIT] && !rtc_apply_q;
  endsequence

  property p_w1s_set;
    s_lock_write |=> ((clock_lock_r & $past(lock_set_bits)) == $past(lock_set_bits));
  endproperty
  a_w1s_set: assert property (p_w1s_set)
    else $error("Lock bit not set by write of one");

  property p_lock_kept;
    !srst |=> ((clock_lock_r & $past(clock_lock_r)) == $past(clock_lock_r));
  endproperty
  a_lock_kept: assert property (p_lock_kept)
    else $error("Lock bit cleared without power reset");

  property p_lock_read;
    s_lock_read |=> (rdata == $past(clock_lock_r)) && ((rdata & ~LOCK_MASK) == ZERO_WORD);
  endproperty
  a_lock_read: assert property (p_lock_read)
    else $error("Lock register read mismatch");

  property p_write_then_read;
    s_lock_write ##2 s_lock_read |=>
      ((rdata & $past(lock_set_bits, 3)) == $past(lock_set_bits, 3));
  endproperty
  a_write_then_read: assert property (p_write_then_read)
    else $error("Written lock bit not visible on read");

  property p_jtag_deny;
    (ce && !srst) |=> (jtag_tap_deny == ($past(otp_area_programmed) && !$past(sec_ovr_q)));
  endproperty
  a_jtag_deny: assert property (p_jtag_deny)
    else $error("JTAG denial does not follow OTP and override");

  property p_sec_held;
    (wr_sec && sec_lock_r && !cold_rst) |=> $stable(security_override);
  endproperty
  a_sec_held: assert property (p_sec_held)
    else $error("Override changed while locked");

  property p_sec_write;
    (wr_sec && !sec_lock_r && !cold_rst) |=> (security_override == $past(req.wdata[0]));
  endproperty
  a_sec_write: assert property (p_sec_write)
    else $error("Override not written");

  property p_sec_lock_sticky;
    (!srst && (sec_lock_r || (wr_sec_lk && req.wdata[0]))) |=> sec_lock_r;
  endproperty
  a_sec_lock_sticky: assert property (p_sec_lock_sticky)
    else $error("Override lock not set or cleared");

  property p_cold_clear;
    (ce && cold_rst) |=> (scratch0_q == SCRATCH_RST) && (scratch1_q == SCRATCH_RST)
                         && !security_override;
  endproperty
  a_cold_clear: assert property (p_cold_clear)
    else $error("Cold reset did not clear sticky fields");

  property p_warm_keep;
    (ce && warm_rst && !cold_rst && !wr_scr0) |=> $stable(scratch0_q);
  endproperty
  a_warm_keep: assert property (p_warm_keep)
    else $error("Scratch lost on warm reset");

  property p_rtc_locked;
    (wr_osc && rtc_locked && !cold_rst) |=> $stable(rtc_div_q) && $stable(rtc_en_q)
                                             && $stable(rtc_apply_q);
  endproperty
  a_rtc_locked: assert property (p_rtc_locked)
    else $error("RTC divider changed while locked");

  property p_apply_pulse;
    (s_apply_rise and !warm_rst) |=> rtc_div_load ##1 (!rtc_div_load || !ce);
  endproperty
  a_apply_pulse: assert property (p_apply_pulse)
    else $error("Divider load pulse missing");

  property p_pd_locked;
    (wr_osc && slow_pd_lk && fast_pd_lk && !cold_rst) |=> $stable(slow_pd_q)
                                                          && $stable(fast_pd_q);
  endproperty
  a_pd_locked: assert property (p_pd_locked)
    else $error("Power-down changed while locked");

endmodule : clock_lock_regs

// ==== test/clock_lock_regs_tb.sv ====
`timescale 1ns/1ps
module clock_lock_regs_tb;
  import clk_lock_pkg::*;

  logic        clk;
  logic        srst;
  logic        ce;
  logic        cold_rst;
  logic        warm_rst;
  reg_req_s    req;
  logic [31:0] rdata;
  logic        otp_area_programmed;
  logic        security_override;
  logic        jtag_tap_deny;
  logic [31:0] clock_locks;
  osc_ctrl_s   osc_ctrl;
  logic        rtc_div_load;
  logic [31:0] exp_locks;
  int          err_total;
  int          cmp_count;
  int          cyc;

  clock_lock_regs dut_u (
    .clk                 (clk),
    .srst                (srst),
    .ce                  (ce),
    .cold_rst            (cold_rst),
    .warm_rst            (warm_rst),
    .req                 (req),
    .rdata               (rdata),
    .otp_area_programmed (otp_area_programmed),
    .security_override   (security_override),
    .jtag_tap_deny       (jtag_tap_deny),
    .clock_locks         (clock_locks),
    .osc_ctrl            (osc_ctrl),
    .rtc_div_load        (rtc_div_load)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Run is a few hundred cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr_reg

  // Read data is valid only in the cycle after the strobe
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check(nm, rdata, exp);
  endtask : rd_chk

  // 0 cold, 1 warm, 2 power-on; one edge long
  task automatic pulse_rst(input int sel);
    @(posedge clk);
    if (sel == 0) cold_rst <= 1'b1;
    if (sel == 1) warm_rst <= 1'b1;
    if (sel == 2) srst <= 1'b1;
    @(posedge clk);
    cold_rst <= 1'b0;
    warm_rst <= 1'b0;
    srst     <= 1'b0;
    #1;
  endtask : pulse_rst

  initial begin
    srst                = 1'b1;
    ce                  = 1'b1;
    cold_rst            = 1'b0;
    warm_rst            = 1'b0;
    req                 = '0;
    otp_area_programmed = 1'b0;
    err_total           = 0;
    cmp_count           = 0;
    cyc                 = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    // Reset values
    rd_chk("locks_rst", OFS_CLOCK_LOCKS, 32'h0000_0000);
    rd_chk("override_rst", OFS_SEC_CTRL, 32'h0000_0000);
    rd_chk("sec_lock_rst", OFS_SEC_LOCK, 32'h0000_0000);
    rd_chk("scratch0_rst", OFS_SCRATCH0, 32'h0000_0000);
    rd_chk("scratch1_rst", OFS_SCRATCH1, 32'h0000_0000);
    rd_chk("osc_rst", OFS_OSC_CTRL, 32'h0000_0006);
    check("deny_no_otp", {31'h0, jtag_tap_deny}, 32'h0000_0000);
    // Oscillator fields while unlocked, then an apply edge
    wr_reg(OFS_OSC_CTRL, 32'h0000_1828);
    check("osc_fields", {24'h0, osc_ctrl}, 32'h0000_0053);
    check("no_load", {31'h0, rtc_div_load}, 32'h0000_0000);
    wr_reg(OFS_OSC_CTRL, 32'h0000_182C);
    check("load_pulse", {31'h0, rtc_div_load}, 32'h0000_0001);
    @(posedge clk);
    #1;
    check("load_end", {31'h0, rtc_div_load}, 32'h0000_0000);
    // Set locks one bit at a time; zeros must leave earlier bits set
    exp_locks = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      wr_reg(OFS_CLOCK_LOCKS, 32'h0000_0001 << i);
      exp_locks = exp_locks | ((32'h0000_0001 << i) & 32'hFFDC_3800);
      check("lock_out", clock_locks, exp_locks);
      rd_chk("lock_reg", OFS_CLOCK_LOCKS, exp_locks);
    end
    wr_reg(OFS_CLOCK_LOCKS, 32'h0000_0000);
    rd_chk("lock_zero_wr", OFS_CLOCK_LOCKS, 32'hFFDC_3800);
    check("lock_bits_4_5", {29'h0, clock_locks[20:18]}, 32'h0000_0007);
    check("lock_bits_5", {29'h0, clock_locks[13:11]}, 32'h0000_0007);
    // Locked oscillator fields ignore writes
    wr_reg(OFS_OSC_CTRL, 32'h0000_0072);
    check("locked_load", {31'h0, rtc_div_load}, 32'h0000_0000);
    check("locked_fields", {24'h0, osc_ctrl}, 32'h0000_005B);
    rd_chk("locked_osc", OFS_OSC_CTRL, 32'h0000_182C);
    // Security override and its lock
    @(posedge clk);
    otp_area_programmed <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("deny_otp", {31'h0, jtag_tap_deny}, 32'h0000_0001);
    wr_reg(OFS_SEC_CTRL, 32'hFFFF_FFFF);
    check("override_set", {31'h0, security_override}, 32'h0000_0001);
    @(posedge clk);
    #1;
    check("deny_overridden", {31'h0, jtag_tap_deny}, 32'h0000_0000);
    rd_chk("override_rd", OFS_SEC_CTRL, 32'h0000_0001);
    wr_reg(OFS_SEC_CTRL, 32'h0000_0000);
    rd_chk("override_clr", OFS_SEC_CTRL, 32'h0000_0000);
    wr_reg(OFS_SEC_CTRL, 32'h0000_0001);
    wr_reg(OFS_SEC_LOCK, 32'hFFFF_FFFF);
    rd_chk("sec_lock_rd", OFS_SEC_LOCK, 32'h0000_0001);
    wr_reg(OFS_SEC_CTRL, 32'h0000_0000);
    rd_chk("override_locked", OFS_SEC_CTRL, 32'h0000_0001);
    // Scratch words, unmapped place and clock enable
    wr_reg(OFS_SCRATCH0, 32'hA5A5_5A5A);
    wr_reg(OFS_SCRATCH1, 32'h1234_5678);
    wr_reg(12'h200, 32'hFFFF_FFFF);
    rd_chk("unmapped", 12'h200, 32'h0000_0000);
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(OFS_SCRATCH0, 32'h0000_FFFF);
    @(posedge clk);
    ce <= 1'b1;
    rd_chk("ce_low_wr", OFS_SCRATCH0, 32'hA5A5_5A5A);
    pulse_rst(1);
    rd_chk("scratch0_warm", OFS_SCRATCH0, 32'hA5A5_5A5A);
    rd_chk("scratch1_warm", OFS_SCRATCH1, 32'h1234_5678);
    rd_chk("override_warm", OFS_SEC_CTRL, 32'h0000_0001);
    pulse_rst(0);
    rd_chk("scratch0_cold", OFS_SCRATCH0, 32'h0000_0000);
    rd_chk("scratch1_cold", OFS_SCRATCH1, 32'h0000_0000);
    rd_chk("override_cold", OFS_SEC_CTRL, 32'h0000_0000);
    rd_chk("locks_cold", OFS_CLOCK_LOCKS, 32'hFFDC_3800);
    rd_chk("sec_lock_cold", OFS_SEC_LOCK, 32'h0000_0001);
    wr_reg(OFS_SEC_CTRL, 32'h0000_0001);
    rd_chk("override_relock", OFS_SEC_CTRL, 32'h0000_0000);
    // Only power-on reset frees the locks
    pulse_rst(2);
    rd_chk("locks_por", OFS_CLOCK_LOCKS, 32'h0000_0000);
    rd_chk("sec_lock_por", OFS_SEC_LOCK, 32'h0000_0000);
    wr_reg(OFS_SEC_CTRL, 32'h0000_0001);
    rd_chk("override_free", OFS_SEC_CTRL, 32'h0000_0001);
    wrap_up();
  end

endmodule : clock_lock_regs_tb
